/* src/lane_setup_pkg.sv */
// Constants and types shared by the lane setup and training bypass block.
`default_nettype none
package lane_setup_pkg;
    // Lane count and lane word width.
    localparam int NUM_LANES   = 4;
    localparam int LANE_WIDTH  = 8;
    // Register bus layout.
    localparam int ADDR_WIDTH  = 4;
    localparam int DATA_WIDTH  = 32;
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_WORDS  = 4'h8;
    // Control register fields.
    localparam int CTRL_BYPASS_BIT  = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int CTRL_CLR_L0_BIT  = 2;
    localparam logic CTRL_BYPASS_RST = 1'b0;
    // Status register fields.
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_L0_SEEN   = 4;
    localparam int STAT_REV_BIT   = 5;
    localparam int STAT_CHAN_LSB  = 8;
    // Training state field codes.
    localparam logic [3:0] CODE_DETECT  = 4'h0;
    localparam logic [3:0] CODE_POLLING = 4'h1;
    localparam logic [3:0] CODE_CONFIG  = 4'h2;
    localparam logic [3:0] CODE_L0      = 4'h3;
    // Reset values.
    localparam logic [15:0] WORDS_RST = 16'h0000;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
    typedef enum logic [1:0] {ST_DETECT, ST_POLLING, ST_CONFIG, ST_L0} ltssm_e;
endpackage
`default_nettype wire

/* src/lane_cross.sv */
// One serial lane word crossing into the user clock domain.
`default_nettype none
module lane_cross
    import lane_setup_pkg::*;
#(
    parameter int W = LANE_WIDTH
) (
    // Clock and reset.
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    // Serial side, foreign domain.
    input  wire logic [W-1:0] ser_data_i,
    input  wire logic         ser_toggle_i,
    // User side.
    output logic      [W-1:0] word_o,
    output logic              pulse_o
);
    logic [W-1:0] data_s1_q;
    logic [W-1:0] data_s2_q;
    logic         tog_s1_q;
    logic         tog_s2_q;
    logic         tog_s3_q;

    // All checks here run on the user clock and sleep during reset.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Two stages for data, three for the toggle; data_s2_q, tog_s2_q and tog_s3_q are read.
    // The source must settle data before it flips the toggle.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_s1_q <= '0;
            data_s2_q <= '0;
            tog_s1_q  <= 1'b0;
            tog_s2_q  <= 1'b0;
            tog_s3_q  <= 1'b0;
        end else begin
            data_s1_q <= ser_data_i;
            data_s2_q <= data_s1_q;
            tog_s1_q  <= ser_toggle_i;
            tog_s2_q  <= tog_s1_q;
            tog_s3_q  <= tog_s2_q;
        end
    end

    // one word per toggle
    // Each toggle edge yields exactly one pulse, so order is kept.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_o  <= '0;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= tog_s2_q ^ tog_s3_q;
            if (tog_s2_q ^ tog_s3_q) begin
                word_o <= data_s2_q;
            end
        end
    end

    a_one_word: assert property (
        (tog_s2_q != tog_s3_q) |=> pulse_o && word_o == $past(data_s2_q))
        else $error("Toggle edge did not deliver its word.");

    a_no_dup: assert property (
        pulse_o |-> $past(tog_s2_q) != $past(tog_s3_q))
        else $error("Word delivered without a toggle edge.");
endmodule
`default_nettype wire

/* src/pcie_lane_setup_train_bypass.sv */
// Lane ordering, channel enabling and training bypass around the link core.
`default_nettype none
module pcie_lane_setup_train_bypass
    import lane_setup_pkg::*;
#(
    parameter int LANES       = NUM_LANES,
    parameter int W           = LANE_WIDTH,
    parameter bit USE_REG_BUS = 1'b1
) (
    // Clock and reset.
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    // Training control, same clock.
    input  wire logic                  train_bypass_i,
    input  wire logic                  train_step_i,
    // Board straps, asynchronous pins.
    input  wire logic                  lane_reverse_i,
    input  wire logic [LANES-1:0]      channel_enable_i,
    // Serial lanes, foreign domain.
    input  wire logic [LANES*W-1:0]    ser_data_i,
    input  wire logic [LANES-1:0]      ser_toggle_i,
    // Register port.
    input  wire logic [ADDR_WIDTH-1:0] addr_i,
    input  wire logic [DATA_WIDTH-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [DATA_WIDTH-1:0] rdata_o,
    // Training state.
    output logic      [3:0]            tx_ltssm_o,
    output logic      [3:0]            rx_ltssm_o,
    output logic                       l0_o,
    // Logical lanes, user side.
    output logic      [LANES*W-1:0]    lane_data_o,
    output logic      [LANES-1:0]      lane_valid_o
);
    ltssm_e           state_q;
    logic             bypass_q;
    logic             l0_seen_q;
    logic [15:0]      words_q;
    logic             rev_s1_q;
    logic             rev_q;
    logic [LANES-1:0] chan_s1_q;
    logic [LANES-1:0] chan_q;
    logic [LANES*W-1:0] cross_word;
    logic [LANES-1:0] cross_pulse;
    logic             bypass_active;
    logic             wr_ctrl;
    logic             restart;
    logic             clr_l0;
    logic [3:0]       state_code;
    logic [DATA_WIDTH-1:0] status_word;

    // Every check in this block runs on the user clock, quiet in reset.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Code carried on the four-bit state field.
    function automatic logic [3:0] code_of(input ltssm_e s);
        case (s)
            ST_DETECT:  code_of = CODE_DETECT;
            ST_POLLING: code_of = CODE_POLLING;
            ST_CONFIG:  code_of = CODE_CONFIG;
            ST_L0:      code_of = CODE_L0;
            default:    code_of = CODE_DETECT;
        endcase
    endfunction

    // reversed lane map
    // Physical channel feeding a logical lane.
    function automatic int phys_of(input int lane, input logic rev);
        phys_of = rev ? (LANES - 1 - lane) : lane;
    endfunction

    // Straps come from pins, so they pass two flip-flops first.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rev_s1_q  <= 1'b0;
            rev_q     <= 1'b0;
            chan_s1_q <= '0;
            chan_q    <= '0;
        end else begin
            rev_s1_q  <= lane_reverse_i;
            rev_q     <= rev_s1_q;
            chan_s1_q <= channel_enable_i;
            chan_q    <= chan_s1_q;
        end
    end

    // Register write decode.
    assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
    assign restart = wr_ctrl && wdata_i[CTRL_RESTART_BIT];
    assign clr_l0  = wr_ctrl && wdata_i[CTRL_CLR_L0_BIT];

    // register bypass bit
    // The bypass bit is held until software writes it back to zero.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bypass_q <= CTRL_BYPASS_RST;
        end else if (wr_ctrl) begin
            bypass_q <= wdata_i[CTRL_BYPASS_BIT];
        end
    end

    // pin or register bypass
    // The pin only counts in the build without the register bus.
    assign bypass_active = USE_REG_BUS ? bypass_q : train_bypass_i;

    // user clock training
    // Bypass outranks restart, so a forced link cannot be knocked down.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_DETECT;
        end else if (bypass_active) begin
            state_q <= ST_L0;
        end else if (restart) begin
            state_q <= ST_DETECT;
        end else if (train_step_i) begin
            case (state_q)
                ST_DETECT:  state_q <= ST_POLLING;
                ST_POLLING: state_q <= ST_CONFIG;
                ST_CONFIG:  state_q <= ST_L0;
                ST_L0:      state_q <= ST_L0;
                default:    state_q <= ST_DETECT;
            endcase
        end
    end

    assign state_code = code_of(state_q);
    assign tx_ltssm_o = state_code;
    assign rx_ltssm_o = state_code;
    assign l0_o       = (state_q == ST_L0);

    // Sticky L0 flag; every cycle spent in L0 wins over a clear.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            l0_seen_q <= 1'b0;
        end else if (state_q == ST_L0) begin
            l0_seen_q <= 1'b1;
        end else if (clr_l0) begin
            l0_seen_q <= 1'b0;
        end
    end

    generate
        for (genvar p = 0; p < LANES; p++) begin : g_cross
            lane_cross #(.W(W)) u_cross (
                .ref_clk_i    (ref_clk_i),
                .resetn_i     (resetn_i),
                .ser_data_i   (ser_data_i[p*W +: W]),
                .ser_toggle_i (ser_toggle_i[p]),
                .word_o       (cross_word[p*W +: W]),
                .pulse_o      (cross_pulse[p])
            );
        end
    endgenerate

    // logical lane ordering
    // A powered-down channel never raises valid on its logical lane.
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_lane
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    lane_data_o[l*W +: W] <= '0;
                    lane_valid_o[l]       <= 1'b0;
                end else begin
                    lane_valid_o[l] <= cross_pulse[phys_of(l, rev_q)]
                                     && chan_q[phys_of(l, rev_q)];
                    lane_data_o[l*W +: W] <=
                        cross_word[phys_of(l, rev_q)*W +: W];
                end
            end
        end
    endgenerate

    // Count of words handed to logical lane 0, wraps silently.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            words_q <= WORDS_RST;
        end else if (lane_valid_o[0]) begin
            words_q <= words_q + 16'h0001;
        end
    end

    // Status word assembly.
    always_comb begin
        status_word = '0;
        status_word[STAT_STATE_LSB +: 4] = state_code;
        status_word[STAT_L0_SEEN]        = l0_seen_q;
        status_word[STAT_REV_BIT]        = rev_q;
        status_word[STAT_CHAN_LSB +: LANES] = chan_q;
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= RDATA_IDLE;
        end else if (rd_i) begin
            case (addr_i)
                OFS_CTRL:   rdata_o <= {31'h0000_0000, bypass_q};
                OFS_STATUS: rdata_o <= status_word;
                OFS_WORDS:  rdata_o <= {16'h0000, words_q};
                default:    rdata_o <= RDATA_IDLE;
            endcase
        end else begin
            rdata_o <= RDATA_IDLE;
        end
    end

    // A bypass write on the register port; never true in the pin build.
    sequence s_bypass_write;
        USE_REG_BUS && wr_i && addr_i == OFS_CTRL
            && wdata_i[CTRL_BYPASS_BIT];
    endsequence

    sequence s_in_l0_two;
        l0_o [*2];
    endsequence

    a_pin_bypass: assert property (
        (!USE_REG_BUS && train_bypass_i) |=> state_code == CODE_L0)
        else $error("Bypass pin did not force L0.");

    // The bit lands at the write edge and steers training one edge later.
    a_reg_bypass: assert property (
        s_bypass_write |=> ##1 s_in_l0_two)
        else $error("Bypass register did not force L0.");

    a_config_step: assert property (
        (state_q == ST_CONFIG && train_step_i && !bypass_active && !restart)
        |=> tx_ltssm_o == CODE_L0 && rx_ltssm_o == CODE_L0)
        else $error("Training did not step from Configuration to L0.");

    a_restart_detect: assert property (
        (restart && !bypass_active) |=> state_code == CODE_DETECT)
        else $error("Restart did not return training to Detect.");

    a_rev_map: assert property (
        (rev_q && $stable(rev_q) && cross_pulse[LANES-1] && chan_q[LANES-1])
        |=> lane_valid_o[0]
            && lane_data_o[W-1:0] == $past(cross_word[(LANES-1)*W +: W]))
        else $error("Reversed channel did not reach logical lane 0.");

    a_natural_map: assert property (
        (!rev_q && cross_pulse[0] && chan_q[0])
        |=> lane_valid_o[0]
            && lane_data_o[W-1:0] == $past(cross_word[W-1:0]))
        else $error("Channel 0 did not reach logical lane 0.");

    a_disabled_quiet: assert property (
        (!rev_q && !chan_q[0]) |=> !lane_valid_o[0])
        else $error("Powered-down channel produced a word.");

    a_rdata_idle: assert property (
        !rd_i |=> rdata_o == RDATA_IDLE)
        else $error("Read data present without a read strobe.");

    a_l0_sticky: assert property (
        l0_o |=> l0_seen_q)
        else $error("L0 arrival was not recorded.");
endmodule
`default_nettype wire

/* sim/lane_partner.sv */
// Serial-side source model that hands lane words over by toggle flips.
`default_nettype none
module lane_partner
    import lane_setup_pkg::*;
(
    // Clock and reset.
    input  wire logic                            ref_clk_i,
    input  wire logic                            resetn_i,
    // Word requests from the bench.
    input  wire logic [NUM_LANES*LANE_WIDTH-1:0] word_i,
    input  wire logic [NUM_LANES-1:0]            send_i,
    // Serial lanes towards the block.
    output logic      [NUM_LANES*LANE_WIDTH-1:0] ser_data_o,
    output logic      [NUM_LANES-1:0]            ser_toggle_o,
    output logic                                 busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = LANE_WIDTH;
    logic [2:0] stage_q [NUM_LANES];

    // word framing per lane
    // Data settle one cycle before the flip and hold four cycles after it.
    // Then they are inverted, so a late sample in the block cannot match.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int p = 0; p < NUM_LANES; p++) stage_q[p] <= 3'h0;
            ser_data_o   <= '0;
            ser_toggle_o <= '0;
        end else begin
            for (int p = 0; p < NUM_LANES; p++) begin
                if (send_i[p] && stage_q[p] == 3'h0) begin
                    ser_data_o[p*W+:W] <= word_i[p*W+:W];
                    stage_q[p]         <= 3'h1;
                end else if (stage_q[p] == 3'h1) begin
                    ser_toggle_o[p] <= ~ser_toggle_o[p];
                    stage_q[p]      <= 3'h2;
                end else if (stage_q[p] == 3'h5) begin
                    ser_data_o[p*W+:W] <= ~ser_data_o[p*W+:W];
                    stage_q[p]         <= 3'h0;
                end else if (stage_q[p] != 3'h0) begin
                    stage_q[p] <= stage_q[p] + 3'h1;
                end
            end
        end
    end

    // Busy while any lane is still inside its hold window.
    always_comb begin
        busy_o = 1'b0;
        for (int p = 0; p < NUM_LANES; p++) busy_o |= (stage_q[p] != 3'h0);
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for lane setup, ordering and training bypass.
`default_nettype none
module tb_top;
    import lane_setup_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = LANE_WIDTH;
    localparam int N = NUM_LANES;
    localparam logic [3:0] CFG_EN [4] = '{4'hf, 4'h1, 4'h8, 4'hf};
    localparam logic [3:0] CFG_REV   = 4'b1100;
    logic           ref_clk_i, resetn_i, bypass, step, rev, wr, rd, l0, l0_2;
    logic           busy;
    logic [N-1:0]   en, send, toggle, valid;
    logic [N*W-1:0] word, sdata, ldata;
    logic [3:0]     addr, tx_code, rx_code, tx2, rx2;
    logic [31:0]    wdata, rdata, v;
    int             err_count = 0, checks_done = 0, cycles = 0, n0 = 0;
    logic [W-1:0]   exp_q [N][$];
    logic [W-1:0]   got_q [N][$];

    // Build with the register bus, where the bypass pin is ignored.
    pcie_lane_setup_train_bypass pcie_lane_setup_train_bypass_i (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .train_bypass_i(bypass),
        .train_step_i(step), .lane_reverse_i(rev), .channel_enable_i(en),
        .ser_data_i(sdata), .ser_toggle_i(toggle), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .tx_ltssm_o(tx_code), .rx_ltssm_o(rx_code), .l0_o(l0),
        .lane_data_o(ldata), .lane_valid_o(valid));
    // Pin build, sharing every input, watched on its training outputs.
    pcie_lane_setup_train_bypass #(.USE_REG_BUS(1'b0)) pin_build_i (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .train_bypass_i(bypass),
        .train_step_i(step), .lane_reverse_i(rev), .channel_enable_i(en),
        .ser_data_i(sdata), .ser_toggle_i(toggle), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(),
        .tx_ltssm_o(tx2), .rx_ltssm_o(rx2), .l0_o(l0_2),
        .lane_data_o(), .lane_valid_o());
    lane_partner lane_partner_i (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .word_i(word),
        .send_i(send), .ser_data_o(sdata), .ser_toggle_o(toggle),
        .busy_o(busy));

    // Clock at 100 ns period.
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Collect delivered words per logical lane; a hang ends the run.
    always @(posedge ref_clk_i) begin
        for (int l = 0; l < N; l++)
            if (valid[l] === 1'b1) got_q[l].push_back(ldata[l*W+:W]);
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata;
    endtask

    task automatic step_once();
        @(posedge ref_clk_i);
        step <= 1'b1;
        @(posedge ref_clk_i);
        step <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    // Training codes of the bus build (a) and of the pin build (b).
    task automatic codes(input logic [3:0] a, b);
        chk("tx code", 32'(a), 32'(tx_code));
        chk("rx code", 32'(a), 32'(rx_code));
        chk("l0 flag", 32'(a == CODE_L0), 32'(l0));
        chk("pin tx code", 32'(b), 32'(tx2));
        chk("pin rx code", 32'(b), 32'(rx2));
        chk("pin l0 flag", 32'(b == CODE_L0), 32'(l0_2));
    endtask

    // One word on every physical lane; expectations follow the lane map.
    task automatic send_words(input int k);
        int t;
        int l;
        logic [N*W-1:0] w;
        w = $urandom;
        if (k == 0) w = '0;
        if (k == 1) w = '1;
        t = 0;
        @(posedge ref_clk_i);
        while (busy !== 1'b0 && t < 20) begin
            @(posedge ref_clk_i);
            t++;
        end
        word <= w;
        send <= '1;
        for (int p = 0; p < N; p++) begin
            l = rev ? N - 1 - p : p;
            if (en[p]) exp_q[l].push_back(w[p*W+:W]);
            if (en[p] && l == 0) n0++;
        end
        @(posedge ref_clk_i);
        send <= '0;
    endtask

    initial begin
        resetn_i = 1'b0;
        {bypass, step, rev, wr, rd} = '0;
        en    = 4'hf;
        send  = '0;
        word  = '0;
        addr  = '0;
        wdata = '0;
        void'($urandom(34245));
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        codes(CODE_DETECT, CODE_DETECT);
        rd_reg(OFS_WORDS, v);
        chk("words reset", 32'h0, v);
        rd_reg(4'hc, v);
        chk("unmapped", 32'h0, v);
        step_once();
        codes(CODE_POLLING, CODE_POLLING);
        step_once();
        codes(CODE_CONFIG, CODE_CONFIG);
        // Bypass only once both fields show Configuration.
        @(posedge ref_clk_i);
        bypass <= 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        codes(CODE_CONFIG, CODE_L0);
        wr_reg(OFS_CTRL, 32'h1);
        // The bit lands at the write edge, the state one edge later.
        @(negedge ref_clk_i);
        codes(CODE_L0, CODE_L0);
        step_once();
        codes(CODE_L0, CODE_L0);
        wr_reg(OFS_CTRL, 32'h3);
        codes(CODE_L0, CODE_L0);
        rd_reg(OFS_STATUS, v);
        chk("status l0", 32'h0000_0f13, v);
        // Restart is refused while bypass holds, so drop bypass first.
        @(posedge ref_clk_i);
        bypass <= 1'b0;
        wr_reg(OFS_CTRL, 32'h0);
        wr_reg(OFS_CTRL, 32'h2);
        codes(CODE_DETECT, CODE_DETECT);
        wr_reg(OFS_CTRL, 32'h4);
        rd_reg(OFS_STATUS, v);
        chk("status clear", 32'h0000_0f00, v);
        // Plain training through Configuration, then a restart.
        repeat (3) step_once();
        codes(CODE_L0, CODE_L0);
        wr_reg(OFS_CTRL, 32'h2);
        codes(CODE_DETECT, CODE_DETECT);
        $display("test training done");
        for (int c = 0; c < 4; c++) begin
            @(posedge ref_clk_i);
            rev <= CFG_REV[c];
            en  <= CFG_EN[c];
            repeat (4) @(posedge ref_clk_i);
            for (int k = 0; k < 4; k++) send_words(k);
            repeat (12) @(posedge ref_clk_i);
            for (int l = 0; l < N; l++) begin
                chk("lane count", exp_q[l].size(), got_q[l].size());
                while (exp_q[l].size() > 0 && got_q[l].size() > 0)
                    chk("lane word", 32'(exp_q[l].pop_front()),
                        32'(got_q[l].pop_front()));
                exp_q[l].delete();
                got_q[l].delete();
            end
            $display("test lanes %0d done", c);
        end
        rd_reg(OFS_WORDS, v);
        chk("words count", 32'(n0), v);
        wrap_up();
    end
endmodule
`default_nettype wire
